// ==== logic/counter_route_pkg.sv ====
// constants shared by the counter input routing block
package counter_route_pkg;
   // function counter positions, one-hot
   localparam int FN_COUNT = 6;
   localparam int FN_KHZ = 0;
   localparam int FN_MHZ = 1;
   localparam int FN_CHB = 2;
   localparam int FN_PERIOD = 3;
   localparam int FN_TOTAL = 4;
   localparam int FN_CHECK = 5;
   // gate counter length, position 0 is the shortest gate
   localparam int GATE_COUNT = 4;
   // digit strobe bit positions
   localparam int STROBE_COUNT = 8;
   localparam int STB_D1 = 0;
   localparam int STB_D3 = 2;
   localparam int STB_D4 = 3;
   localparam int STB_D8 = 7;
   // front panel button indices
   localparam int BTN_COUNT = 3;
   localparam int BTN_HOLD = 0;
   localparam int BTN_FUNCTION_SELECT_BUTTON = 1;
   localparam int BTN_GATE = 2;
   // divider ratios
   localparam int DIRECT_DIV_RATIO = 10;
   localparam int PRESCALER_RATIO = 64;
   localparam int PRESCALED_DIV_RATIO = 5;
   localparam int TOTAL_PRESCALE_RATIO = PRESCALER_RATIO * PRESCALED_DIV_RATIO;
   localparam int DIV_CNT_W = 4;
   localparam logic [DIV_CNT_W-1:0] DIV_CNT_ZERO = 4'h0;
   localparam logic [DIV_CNT_W-1:0] DIV_CNT_ONE = 4'h1;
   // clock
   localparam int CLK_PERIOD_NS = 50;
endpackage

// ==== logic/onehot_ring.sv ====
// one-hot ring counter that steps once per advance pulse
`timescale 1ns/1ps
module onehot_ring #(
   parameter int N = 4
) (
   // clock and reset
   input wire logic clk,
   input wire logic rst_n,
   input wire logic ce,
   // step request
   input wire logic advance,
   // position
   output logic [N-1:0] pos_q
);
   localparam logic [N-1:0] FIRST = {{(N-1){1'b0}}, 1'b1};

   if (N < 2)
   begin : g_chk
      $error("onehot_ring needs at least two positions");
   end

   always_ff @(posedge clk or negedge rst_n)
   begin
      if (!rst_n)
         pos_q <= FIRST;
      else if (ce && advance)
         pos_q <= {pos_q[N-2:0], pos_q[N-1]};
   end
endmodule // onehot_ring

// ==== logic/counter_route.sv ====
// input routing, totalize gating and strobe feedback for the counter chip
//
// Function
// - invert squared direct input before use
// - decade counter divides inverted input by ten
// - MHz function forwards divided direct signal
// - prescaled input arrives already divided by 64
// - divide prescaled signal by five, top stage
// - overall prescaled division is 320
// - prescaled function forwards divide-by-320 signal
// - undriven start/stop input reads as high
// - hold button debounced by set/reset latch
// - totalize gates input by hold and start/stop
// - totalize-enable high when totalize selected
// - routed strobes set chip mode and resolution
// - function control gets D1, D3, D4 or D8
// - range control gets one of D1-D4
// - one-hot function counter, button advances it
// - one-hot gate counter, button advances it
// - function starts at kHz frequency
// - gate starts at shortest gate time
// - hold in totalize truly stops counting
`timescale 1ns/1ps
module counter_route
   import counter_route_pkg::*;
#(
   parameter int DIRECT_DIV = counter_route_pkg::DIRECT_DIV_RATIO,
   parameter int PRESCALED_DIV = counter_route_pkg::PRESCALED_DIV_RATIO
) (
   // clock, reset, enable
   input wire logic clk,
   input wire logic nrst,
   input wire logic ce,
   // signal inputs, already squared
   input wire logic direct_in,
   input wire logic prescaled_input,
   // rear panel start/stop jack
   input wire logic start_stop_in,
   input wire logic start_stop_connected,
   // panel buttons, two contacts each, active low
   input wire logic [counter_route_pkg::BTN_COUNT-1:0] btn_press_n,
   input wire logic [counter_route_pkg::BTN_COUNT-1:0] btn_release_n,
   // digit strobes from the counter chip
   input wire logic [counter_route_pkg::STROBE_COUNT-1:0] digit_select_strobes,
   // towards the counter chip
   output logic counter_in_q,
   output logic function_ctl_q,
   output logic range_ctl_q,
   output logic hold_q,
   // status
   output logic totalize_en,
   output logic [counter_route_pkg::FN_COUNT-1:0] function_pos_q,
   output logic [counter_route_pkg::GATE_COUNT-1:0] gate_pos_q
);
   import counter_route_pkg::*;

   if (DIRECT_DIV < 2 || DIRECT_DIV > 15 || PRESCALED_DIV < 2 || PRESCALED_DIV > 15)
   begin : g_chk
      $error("divider ratio outside 2..15");
   end

   localparam logic [DIV_CNT_W-1:0] DIRECT_LAST = DIV_CNT_W'(DIRECT_DIV - 1);
   localparam logic [DIV_CNT_W-1:0] DIRECT_HALF = DIV_CNT_W'(DIRECT_DIV / 2);
   localparam logic [DIV_CNT_W-1:0] PRESC_LAST = DIV_CNT_W'(PRESCALED_DIV - 1);

   logic rst_meta_q;
   logic rst_n_q;
   logic direct_inv_q;
   logic direct_inv_prev_q;
   logic presc_q;
   logic presc_prev_q;
   logic [DIV_CNT_W-1:0] direct_cnt_q;
   logic [DIV_CNT_W-1:0] presc_cnt_q;
   logic [BTN_COUNT-1:0] deb_q;
   logic [BTN_COUNT-1:0] deb_prev_q;
   logic [BTN_COUNT-1:0] deb_d;
   logic hold_press;

   // reset release through two flops
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         rst_meta_q <= 1'b0;
         rst_n_q <= 1'b0;
      end
      else
      begin
         rst_meta_q <= 1'b1;
         rst_n_q <= rst_meta_q;
      end
   end

   // input capture; edges counted at clk rate, so inputs above clk/2 alias
   always_ff @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         // reset high, so neither idle level fakes a first edge
         direct_inv_q <= 1'b1;
         direct_inv_prev_q <= 1'b1;
         presc_q <= 1'b1;
         presc_prev_q <= 1'b1;
      end
      else if (ce)
      begin
         direct_inv_q <= ~direct_in;
         direct_inv_prev_q <= direct_inv_q;
         presc_q <= prescaled_input;
         presc_prev_q <= presc_q;
      end
   end

   wire direct_rise = direct_inv_q & ~direct_inv_prev_q;
   wire presc_rise = presc_q & ~presc_prev_q;

   always_ff @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
         direct_cnt_q <= DIV_CNT_ZERO;
      else if (ce && direct_rise)
         direct_cnt_q <= (direct_cnt_q == DIRECT_LAST) ? DIV_CNT_ZERO
                                                       : direct_cnt_q + DIV_CNT_ONE;
   end

   always_ff @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
         presc_cnt_q <= DIV_CNT_ZERO;
      else if (ce && presc_rise)
         presc_cnt_q <= (presc_cnt_q == PRESC_LAST) ? DIV_CNT_ZERO
                                                    : presc_cnt_q + DIV_CNT_ONE;
   end

   // divided outputs; the /5 output is high only in its last state
   wire direct_div_out = (direct_cnt_q >= DIRECT_HALF);
   wire presc_div_out = (presc_cnt_q == PRESC_LAST);

   // contact latches: press contact sets, release contact clears, both open keeps
   for (genvar b = 0; b < BTN_COUNT; b++)
   begin : g_btn
      assign deb_d[b] = (!btn_press_n[b] && btn_release_n[b]) ? 1'b1 :
                        (btn_press_n[b] && !btn_release_n[b]) ? 1'b0 : deb_q[b];
   end

   always_ff @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         deb_q <= {BTN_COUNT{1'b0}};
         deb_prev_q <= {BTN_COUNT{1'b0}};
      end
      else if (ce)
      begin
         deb_q <= deb_d;
         deb_prev_q <= deb_q;
      end
   end

   wire function_select_button_step = deb_q[BTN_FUNCTION_SELECT_BUTTON] & ~deb_prev_q[BTN_FUNCTION_SELECT_BUTTON];
   wire gate_step = deb_q[BTN_GATE] & ~deb_prev_q[BTN_GATE];
   assign hold_press = deb_q[BTN_HOLD];

   onehot_ring #(
      .N(FN_COUNT)
   ) u_function_ring (
      .clk(clk),
      .rst_n(rst_n_q),
      .ce(ce),
      .advance(function_select_button_step),
      .pos_q(function_pos_q)
   );

   onehot_ring #(
      .N(GATE_COUNT)
   ) u_gate_ring (
      .clk(clk),
      .rst_n(rst_n_q),
      .ce(ce),
      .advance(gate_step),
      .pos_q(gate_pos_q)
   );

   // selection
   assign totalize_en = function_pos_q[FN_TOTAL];
   wire start_stop_ok = start_stop_connected ? start_stop_in : 1'b1;
   wire direct_path = function_pos_q[FN_MHZ] ? direct_div_out : direct_inv_q;
   wire routed = function_pos_q[FN_CHB] ? presc_div_out : direct_path;
   wire gated = direct_path & ~hold_press & start_stop_ok;
   wire counter_in_d = totalize_en ? gated : routed;

   // strobe feedback to the chip control inputs
   wire fn_on_d1 = function_pos_q[FN_KHZ] | function_pos_q[FN_MHZ] | function_pos_q[FN_CHB];
   wire function_ctl_d = (fn_on_d1 & digit_select_strobes[STB_D1]) |
                         (function_pos_q[FN_CHECK] & digit_select_strobes[STB_D3]) |
                         (function_pos_q[FN_TOTAL] & digit_select_strobes[STB_D4]) |
                         (function_pos_q[FN_PERIOD] & digit_select_strobes[STB_D8]);
   wire range_ctl_d = |(gate_pos_q & digit_select_strobes[GATE_COUNT-1:0]);

   // one register stage; strobe slots far outlast a 50 ns delay
   always_ff @(posedge clk or negedge rst_n_q)
   begin
      if (!rst_n_q)
      begin
         counter_in_q <= 1'b0;
         function_ctl_q <= 1'b0;
         range_ctl_q <= 1'b0;
         hold_q <= 1'b0;
      end
      else if (ce)
      begin
         counter_in_q <= counter_in_d;
         function_ctl_q <= function_ctl_d;
         range_ctl_q <= range_ctl_d;
         hold_q <= hold_press;
      end
   end

   property p_fn_onehot;
      @(posedge clk) disable iff (!rst_n_q)
      $onehot(function_pos_q);
   endproperty
   a_fn_onehot: assert property (p_fn_onehot)
      else $error("function position not one-hot");

   property p_gate_onehot;
      @(posedge clk) disable iff (!rst_n_q)
      $onehot(gate_pos_q);
   endproperty
   a_gate_onehot: assert property (p_gate_onehot)
      else $error("gate position not one-hot");

   property p_fn_reset;
      @(posedge clk) $rose(rst_n_q) |-> function_pos_q[FN_KHZ] && gate_pos_q[0];
   endproperty
   a_fn_reset: assert property (p_fn_reset)
      else $error("power-on position wrong");

   property p_fn_step;
      @(posedge clk) disable iff (!rst_n_q)
      (ce && function_select_button_step) |=> function_pos_q == {$past(function_pos_q[FN_COUNT-2:0]),
                                               $past(function_pos_q[FN_COUNT-1])};
   endproperty
   a_fn_step: assert property (p_fn_step)
      else $error("function did not step by one");

   property p_gate_still;
      @(posedge clk) disable iff (!rst_n_q)
      !gate_step |=> $stable(gate_pos_q);
   endproperty
   a_gate_still: assert property (p_gate_still)
      else $error("gate moved without press");

   property p_hold_blocks;
      @(posedge clk) disable iff (!rst_n_q)
      (ce && totalize_en && hold_press) |=> !counter_in_q;
   endproperty
   a_hold_blocks: assert property (p_hold_blocks)
      else $error("hold did not stop totalize input");

   property p_chb_route;
      @(posedge clk) disable iff (!rst_n_q)
      (ce && function_pos_q[FN_CHB]) |=> counter_in_q == $past(presc_div_out);
   endproperty
   a_chb_route: assert property (p_chb_route)
      else $error("prescaled path not forwarded");

   // sampled reset in the antecedent keeps the release edge out: outputs still reset there
   property p_khz_route;
      @(posedge clk) disable iff (!rst_n_q)
      (rst_n_q && ce && function_pos_q[FN_KHZ]) |=> counter_in_q == $past(direct_inv_q);
   endproperty
   a_khz_route: assert property (p_khz_route)
      else $error("undivided path not forwarded");

   property p_mhz_route;
      @(posedge clk) disable iff (!rst_n_q)
      (rst_n_q && ce && function_pos_q[FN_MHZ]) |=> counter_in_q == $past(direct_div_out);
   endproperty
   a_mhz_route: assert property (p_mhz_route)
      else $error("divided path not forwarded");

   property p_total_free;
      @(posedge clk) disable iff (!rst_n_q)
      (rst_n_q && ce && totalize_en && !hold_press && !start_stop_connected) |=>
         counter_in_q == $past(direct_inv_q);
   endproperty
   a_total_free: assert property (p_total_free)
      else $error("open start/stop jack blocked totalize input");

   property p_total_stop;
      @(posedge clk) disable iff (!rst_n_q)
      (ce && totalize_en && start_stop_connected && !start_stop_in) |=> !counter_in_q;
   endproperty
   a_total_stop: assert property (p_total_stop)
      else $error("start/stop low did not stop totalize input");

   property p_period_strobe;
      @(posedge clk) disable iff (!rst_n_q)
      (ce && function_pos_q[FN_PERIOD]) |=> function_ctl_q == $past(digit_select_strobes[STB_D8]);
   endproperty
   a_period_strobe: assert property (p_period_strobe)
      else $error("period not routed to D8");

   property p_range_first;
      @(posedge clk) disable iff (!rst_n_q)
      (rst_n_q && ce && gate_pos_q[0]) |=> range_ctl_q == $past(digit_select_strobes[STB_D1]);
   endproperty
   a_range_first: assert property (p_range_first)
      else $error("shortest gate not routed to D1");

   property p_presc_wrap;
      @(posedge clk) disable iff (!rst_n_q)
      presc_cnt_q <= PRESC_LAST;
   endproperty
   a_presc_wrap: assert property (p_presc_wrap)
      else $error("divide-by-five count out of range");
endmodule // counter_route

// ==== bench/strobe_source.sv ====
// digit strobe source standing in for the counter chip's display multiplexer
`timescale 1ns/1ps
module strobe_source #(
   parameter int SLOT = 3
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // digit strobes, bit 0 is the first digit
   output logic [7:0] strobes
);
   int slot_q;

   // one strobe high at a time, walking up and round again
   always_ff @(posedge clk or negedge nrst)
   begin
      if (!nrst)
      begin
         strobes <= 8'h01;
         slot_q <= 0;
      end
      else if (slot_q == SLOT - 1)
      begin
         strobes <= {strobes[6:0], strobes[7]};
         slot_q <= 0;
      end
      else
      begin
         slot_q <= slot_q + 1;
      end
   end
endmodule // strobe_source

// ==== bench/tb_counter_route.sv ====
// self-checking bench for the counter input routing block
`timescale 1ns/1ps
module tb_counter_route;
   import counter_route_pkg::*;
   logic clk = 0;
   logic nrst = 0;
   logic ce = 1;
   logic direct_in = 0;
   logic prescaled_input = 0;
   logic start_stop_in = 0;
   logic start_stop_connected = 0;
   logic [2:0] btn_press_n = 3'h7;
   logic [2:0] btn_release_n = 3'h7;
   logic [7:0] strobes;
   logic counter_in_q;
   logic function_ctl_q;
   logic range_ctl_q;
   logic hold_q;
   logic totalize_en;
   logic [5:0] function_pos_q;
   logic [3:0] gate_pos_q;
   logic [9:0] exp_q[$];
   int mismatches = 0;
   int n_tests = 0;
   int seed = 59;
   int rises = 0;
   int fn = 0;
   int gt = 0;
   // rising edges at the chip per 100 input periods, by function
   localparam int RATIO[6] = '{100, 100 / DIRECT_DIV_RATIO, 100 / PRESCALED_DIV_RATIO,
                               100, 100, 100};

   always #(CLK_PERIOD_NS / 2) clk = ~clk;
   always @(posedge counter_in_q) rises++;

   strobe_source u_strobes (.clk(clk), .nrst(nrst), .strobes(strobes));

   counter_route u_dut (
      .clk(clk), .nrst(nrst), .ce(ce), .direct_in(direct_in),
      .prescaled_input(prescaled_input), .start_stop_in(start_stop_in),
      .start_stop_connected(start_stop_connected), .btn_press_n(btn_press_n),
      .btn_release_n(btn_release_n), .digit_select_strobes(strobes),
      .counter_in_q(counter_in_q), .function_ctl_q(function_ctl_q),
      .range_ctl_q(range_ctl_q), .hold_q(hold_q), .totalize_en(totalize_en),
      .function_pos_q(function_pos_q), .gate_pos_q(gate_pos_q)
   );

   task automatic check(input logic [9:0] seen, input logic [9:0] want);
      n_tests++;
      if (seen !== want)
      begin
         mismatches++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, want);
      end
   endtask

   task automatic conclude();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("RESULT: PASS");
      else
         $display("RESULT: FAIL");
      $finish;
   endtask

   // changeover contact: press side closed or release side closed
   task automatic btn(input int b, input logic p);
      @(negedge clk);
      btn_press_n[b] = !p;
      btn_release_n[b] = p;
   endtask

   task automatic step(input int b);
      if (b == BTN_FUNCTION_SELECT_BUTTON)
         fn = (fn + 1) % FN_COUNT;
      else
         gt = (gt + 1) % GATE_COUNT;
      exp_q.push_back({6'h01 << fn, 4'h1 << gt});
      btn(b, 1'b1);
      repeat (2) @(negedge clk);
      btn(b, 1'b0);
      repeat (3) @(negedge clk);
   endtask

   task automatic route(input int n);
      logic [7:0] s;
      int fsel;
      fsel = (fn == FN_PERIOD) ? STB_D8 : (fn == FN_TOTAL) ? STB_D4 :
         (fn == FN_CHECK) ? STB_D3 : STB_D1;
      repeat (n)
      begin
         @(negedge clk);
         s = strobes;
         @(negedge clk);
         check(function_ctl_q, s[fsel]);
         check(range_ctl_q, s[gt]);
         check(totalize_en, fn == FN_TOTAL);
      end
   endtask

   // settle first so edges caused by earlier changes stay out of the window
   task automatic run(input logic [9:0] want);
      int base;
      int hi;
      repeat (4) @(negedge clk);
      base = rises;
      repeat (100)
      begin
         hi = 2 + ($random(seed) & 1);
         @(negedge clk);
         direct_in = 1;
         prescaled_input = 1;
         repeat (hi) @(negedge clk);
         direct_in = 0;
         prescaled_input = 0;
         repeat (2) @(negedge clk);
      end
      repeat (4) @(negedge clk);
      check(10'(rises - base), want);
   endtask

   initial
   begin
      @(posedge nrst);
      forever
      begin
         @(function_pos_q or gate_pos_q);
         #1;
         check({function_pos_q, gate_pos_q}, exp_q.size() ? exp_q.pop_front() : 10'h000);
      end
   end

   initial
   begin
      #(CLK_PERIOD_NS * 40000);
      mismatches++;
      conclude();
   end

   initial
   begin
      repeat (16) @(negedge clk);
      nrst = 1;
      repeat (4) @(negedge clk);
      check(function_pos_q, 6'h01);
      check(gate_pos_q, 4'h1);
      check(counter_in_q, 1'b1);
      repeat (FN_COUNT)
      begin
         route(24);
         run(10'(RATIO[fn]));
         if (fn == FN_TOTAL)
         begin
            btn(BTN_HOLD, 1'b1);
            repeat (3) @(negedge clk);
            check(hold_q, 1'b1);
            run(10'h000);
            btn(BTN_HOLD, 1'b0);
            start_stop_connected = 1;
            repeat (3) @(negedge clk);
            check(hold_q, 1'b0);
            run(10'h000);
            start_stop_in = 1;
            run(10'h064);
            start_stop_connected = 0;
            start_stop_in = 0;
         end
         step(BTN_FUNCTION_SELECT_BUTTON);
      end
      repeat (GATE_COUNT)
      begin
         step(BTN_GATE);
         route(24);
      end
      // clock enable low freezes the whole input path
      ce = 1'b0;
      run(10'h000);
      ce = 1'b1;
      // reset in mid-run from a non-initial position
      step(BTN_FUNCTION_SELECT_BUTTON);
      step(BTN_GATE);
      exp_q.push_back({6'h01, 4'h1});
      nrst = 1'b0;
      repeat (2) @(negedge clk);
      nrst = 1'b1;
      fn = 0;
      gt = 0;
      repeat (4) @(negedge clk);
      check(function_pos_q, 6'h01);
      check(gate_pos_q, 4'h1);
      check(counter_in_q, 1'b1);
      route(24);
      repeat (4) @(negedge clk);
      check(10'(exp_q.size()), 10'h000);
      conclude();
   end
endmodule // tb_counter_route
